// ---- hw/ldc_pkg.sv ----
// Package: constants and carrier types for the dimming and calibration control block
package ldc_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned CLK_FREQ_KHZ     = 25000;

  // Non-overlap delays in ns
  localparam int unsigned LS_HS_DLY_MIN_NS = 15;
  localparam int unsigned LS_HS_DLY_TYP_NS = 30;
  localparam int unsigned LS_HS_DLY_MAX_NS = 40;
  localparam int unsigned HS_LS_DLY_MIN_NS = 35;
  localparam int unsigned HS_LS_DLY_TYP_NS = 60;
  localparam int unsigned HS_LS_DLY_MAX_NS = 75;
  // Least times round up, never below one cycle
  localparam int unsigned LS_HS_DLY_CYC    =
    ((LS_HS_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((LS_HS_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned HS_LS_DLY_CYC    =
    ((HS_LS_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((HS_LS_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Calibration run time in us
  localparam int unsigned CAL_TIME_US      = 200;
  localparam int unsigned CAL_TIME_CYC     = CAL_TIME_US * CLK_FREQ_KHZ / 1000;

  localparam int unsigned DIM_W            = 8;
  localparam int unsigned CAL_W            = 8;
  localparam logic [7:0]  DIM_TEN_PCT      = 8'h18;
  localparam logic [7:0]  DIM_RST          = 8'hff;
  localparam logic [7:0]  CAL_RST          = 8'h00;
  localparam logic [1:0]  MODE_NONE        = 2'h0;
  localparam logic [1:0]  MODE_RST         = 2'h0;

  typedef enum logic [1:0] {
    LDC_CAL_IDLE,
    LDC_CAL_RUN
  } ldc_cal_st_t;

  typedef enum logic [1:0] {
    LDC_GD_LOW,
    LDC_GD_L2H,
    LDC_GD_HIGH,
    LDC_GD_H2L
  } ldc_gd_st_t;

  typedef struct packed {
    logic high_side;
    logic low_side;
  } ldc_gate_t;

  typedef struct packed {
    ldc_cal_st_t             cal_st;
    logic [12:0]             cal_cnt;
    logic                    cal_done;
    logic [CAL_W-1:0]        cal_result;
    logic [CAL_W-1:0]        cal_eff;
    logic [DIM_W-1:0]        dim_level;
    logic                    lh;
    logic [1:0]              mode_fb;
    ldc_gd_st_t              gd_st;
    logic [2:0]              gd_cnt;
    ldc_gate_t               gate;
    logic                    drv_en;
  } ldc_state_t;

endpackage

// ---- hw/ldc_ctrl.sv ----
// Dimming, limp-home, calibration and gate non-overlap control
//
// Function
// (R1) Dimming pulse input high enables main switch gate drivers, low disables them.
// (R2) While pulse input low, mode feedback holds last high-phase mode, never none; code reads none (MODE_RST) from reset until a first real mode.
// (R3) Host should not hold pulse input low long to suspend current.
// (R4) Host stops safely via idle bit or enable undervoltage input low.
// (R5) Outside limp-home, load current scales with the 8-bit analog dim value.
// (R6) Dim value 24 is ten percent; calibrated accuracy within ten percent.
// (R7) Limp-home input high puts the device into limp-home state.
// (R8) Switching needs both pulse input and enable input high, even in limp-home.
// (R9) In limp-home the dim level comes from the setpoint pin.
// (R10) Outside limp-home the setpoint pin is ignored.
// (R11) Host zeroes output current during calibration: pulse low, load disconnected.
// (R12) Host then promptly sets the calibration enable bit.
// (R13) Host then promptly sets calibration start to launch the routine.
// (R14) Device sets calibration done about 200 us after start.
// (R15) After calibration the correction is applied automatically.
// (R16) Enable high: circuitry uses routine result; value field reads that result.
// (R17) Enable low: host value used and read back; start requests inhibited.
// (R18) Host should recalibrate whenever pulse input stays low long enough.
// (R19) Low-side off to high-side on waits 15 to 40 ns.
// (R20) High-side off to low-side on waits 35 to 75 ns.
// (R21) Accepted calibration start clears the done flag.
`timescale 1ns/100ps

module ldc_ctrl
  import ldc_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = CAL_TIME_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             dimming_pulse_input_i,
  input  wire logic             enable_undervoltage_input_i,
  input  wire logic             idle_i,
  input  wire logic             limp_home_input_i,
  input  wire logic [DIM_W-1:0] analog_dim_value_i,
  input  wire logic [DIM_W-1:0] setpoint_level_i,
  input  wire logic             calibration_enable_i,
  input  wire logic             calibration_start_i,
  input  wire logic [CAL_W-1:0] calibration_value_wr_i,
  input  wire logic [CAL_W-1:0] cal_measure_i,
  input  wire logic [1:0]       regulation_mode_i,
  input  wire logic             pwm_hs_req_i,
  output logic                  calibration_done_o,
  output logic                  cal_busy_o,
  output logic [CAL_W-1:0]      calibration_value_o,
  output logic [CAL_W-1:0]      cal_trim_o,
  output logic [DIM_W-1:0]      dim_level_o,
  output logic                  limp_home_o,
  output logic [1:0]            regulation_mode_feedback_o,
  output logic                  drivers_enabled_o,
  output logic                  high_side_gate_drive_o,
  output logic                  low_side_gate_drive_o
);

  ldc_state_t s_q;
  ldc_state_t s_d;
  logic       run_ok;
  logic       want_hs;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    // Idle bit also stops switching so the host has a safe stop path
    run_ok = dimming_pulse_input_i && enable_undervoltage_input_i && !idle_i; // R1 R4 R8
    want_hs = run_ok && pwm_hs_req_i;

    s_d.drv_en = run_ok; // R1 R8
    s_d.lh = limp_home_input_i; // R7
    if (limp_home_input_i) begin
      s_d.dim_level = setpoint_level_i; // R9
    end else begin
      s_d.dim_level = analog_dim_value_i; // R5 R6 R10
    end

    // Keep the last real mode across low phases
    if (dimming_pulse_input_i && regulation_mode_i != MODE_NONE) begin
      s_d.mode_fb = regulation_mode_i; // R2
    end

    // Calibration routine
    unique case (s_q.cal_st)
      LDC_CAL_IDLE: begin
        if (calibration_start_i && calibration_enable_i) begin // R17
          s_d.cal_st = LDC_CAL_RUN;
          s_d.cal_cnt = '0;
          s_d.cal_done = 1'b0; // R21
        end
      end
      LDC_CAL_RUN: begin
        if (!calibration_enable_i) begin
          s_d.cal_st = LDC_CAL_IDLE;
        end else if (s_q.cal_cnt == 13'(CAL_CYCLES - 1)) begin
          s_d.cal_st = LDC_CAL_IDLE;
          s_d.cal_done = 1'b1; // R14
          s_d.cal_result = cal_measure_i; // R15
        end else begin
          s_d.cal_cnt = s_q.cal_cnt + 13'h0001;
        end
      end
      default: s_d.cal_st = LDC_CAL_IDLE;
    endcase

    if (calibration_enable_i) begin
      s_d.cal_eff = s_d.cal_result; // R16
    end else begin
      s_d.cal_eff = calibration_value_wr_i; // R17
    end

    // Gate non-overlap sequencer; neither side is on during a gap
    unique case (s_q.gd_st)
      LDC_GD_LOW: begin
        if (want_hs) begin
          s_d.gd_st = LDC_GD_L2H;
          s_d.gd_cnt = '0;
          s_d.gate = '0;
        end else begin
          s_d.gate = '{high_side: 1'b0, low_side: run_ok};
        end
      end
      LDC_GD_L2H: begin
        if (!want_hs) begin
          s_d.gd_st = LDC_GD_LOW;
        end else if (s_q.gd_cnt == 3'(LS_HS_DLY_CYC - 1)) begin // R19
          s_d.gd_st = LDC_GD_HIGH;
          s_d.gate = '{high_side: 1'b1, low_side: 1'b0};
        end else begin
          s_d.gd_cnt = s_q.gd_cnt + 3'h1;
        end
      end
      LDC_GD_HIGH: begin
        if (!want_hs) begin
          s_d.gd_st = LDC_GD_H2L;
          s_d.gd_cnt = '0;
          s_d.gate = '0;
        end
      end
      LDC_GD_H2L: begin
        if (s_q.gd_cnt == 3'(HS_LS_DLY_CYC - 1)) begin // R20
          s_d.gd_st = LDC_GD_LOW;
          s_d.gate = '{high_side: 1'b0, low_side: run_ok};
        end else begin
          s_d.gd_cnt = s_q.gd_cnt + 3'h1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q.cal_st     <= LDC_CAL_IDLE;
      s_q.cal_cnt    <= '0;
      s_q.cal_done   <= 1'b0;
      s_q.cal_result <= CAL_RST;
      s_q.cal_eff    <= CAL_RST;
      s_q.dim_level  <= DIM_RST;
      s_q.lh         <= 1'b0;
      s_q.mode_fb    <= MODE_RST;
      s_q.gd_st      <= LDC_GD_LOW;
      s_q.gd_cnt     <= '0;
      s_q.gate       <= '0;
      s_q.drv_en     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign calibration_done_o         = s_q.cal_done;
  assign cal_busy_o                 = (s_q.cal_st == LDC_CAL_RUN);
  assign calibration_value_o        = s_q.cal_eff; // R16 R17
  assign cal_trim_o                 = s_q.cal_eff; // R15
  assign dim_level_o                = s_q.dim_level;
  assign limp_home_o                = s_q.lh;
  assign regulation_mode_feedback_o = s_q.mode_fb;
  assign drivers_enabled_o          = s_q.drv_en;
  assign high_side_gate_drive_o     = s_q.gate.high_side;
  assign low_side_gate_drive_o      = s_q.gate.low_side;

endmodule

// ---- testbench/ldc_ctrl_props.sv ----
// Port checker for the dimming, gate and calibration control
`timescale 1ns/100ps
module ldc_ctrl_props
  import ldc_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = CAL_TIME_CYC
) (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       dimming_pulse_input_i,
  input wire logic       enable_undervoltage_input_i,
  input wire logic       limp_home_input_i,
  input wire logic [7:0] setpoint_level_i,
  input wire logic       calibration_enable_i,
  input wire logic       calibration_start_i,
  input wire logic       calibration_done_o,
  input wire logic       cal_busy_o,
  input wire logic [7:0] dim_level_o,
  input wire logic [1:0] regulation_mode_feedback_o,
  input wire logic       drivers_enabled_o,
  input wire logic       high_side_gate_drive_o,
  input wire logic       low_side_gate_drive_o
);
  logic [12:0] busy_q;
  // Counts run length so the done moment is tied to start
  always_ff @(posedge clk_i) begin
    busy_q <= (resetn_i && cal_busy_o) ? busy_q + 13'h1 : 13'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////
  a_drive_gate: assert property (
    !(dimming_pulse_input_i && enable_undervoltage_input_i) |=> !drivers_enabled_o)
    else $error("drivers on");
  a_ls_hs_gap: assert property (
    $rose(high_side_gate_drive_o) |-> !$past(low_side_gate_drive_o)) else $error("hs gap");
  a_hs_ls_gap: assert property (
    $rose(low_side_gate_drive_o) |-> !$past(high_side_gate_drive_o)) else $error("ls gap");
  a_mode_hold: assert property (
    !$past(dimming_pulse_input_i) |-> $stable(regulation_mode_feedback_o)) else $error("mode");
  a_limp_dim: assert property (
    limp_home_input_i |=> dim_level_o == $past(setpoint_level_i)) else $error("limp dim");
  a_cal_take: assert property (
    calibration_start_i && calibration_enable_i && !cal_busy_o |=>
    cal_busy_o && !calibration_done_o) else $error("take");
  a_cal_time: assert property (
    $rose(calibration_done_o) |-> busy_q == 13'(CAL_CYCLES)) else $error("run time");
  a_cal_refuse: assert property (
    !calibration_enable_i |=> !cal_busy_o) else $error("refuse");
  c_done: cover property ($rose(calibration_done_o));
  c_high: cover property ($rose(high_side_gate_drive_o));
  c_limp: cover property (limp_home_input_i);
endmodule
bind ldc_ctrl ldc_ctrl_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (.*);

// ---- testbench/ldc_host_model.sv ----
// Host model: dimming pulse and calibration request sequence
`timescale 1ns/100ps
module ldc_host_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic pwm_i,
  input  wire logic kick_i,
  output logic      pulse_o,
  output logic      en_o,
  output logic      start_o
);
  logic [1:0] step_q = 2'h0;
  always @(posedge clk_i) begin
    step_q <= !go_i ? 2'h0 : (step_q == 2'h3 ? 2'h3 : step_q + 2'h1);
  end
  // Pulse follows pwm_i and is forced low only around a run, never to park the output
  assign pulse_o = pwm_i && !go_i;
  assign en_o    = step_q != 2'h0;
  assign start_o = step_q == 2'h2 || kick_i;
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the dimming and calibration control
`timescale 1ns/100ps
module tb;
  import ldc_pkg::*;
  localparam int unsigned CAL = 20;
  logic clk_i = 0, resetn_i = 0, enable_undervoltage_input_i = 0, idle_i = 0, go = 0;
  logic limp_home_input_i = 0, pwm_hs_req_i = 0, pwm = 0, kick = 0;
  logic [7:0] analog_dim_value_i = 0, setpoint_level_i = 0, calibration_value_wr_i = 0;
  logic [7:0] cal_measure_i = 0, calibration_value_o, cal_trim_o, dim_level_o;
  logic [1:0] regulation_mode_i = 0, em = 0, regulation_mode_feedback_o;
  logic dimming_pulse_input_i, calibration_enable_i, calibration_start_i, calibration_done_o;
  logic cal_busy_o, limp_home_o, drivers_enabled_o, high_side_gate_drive_o;
  logic low_side_gate_drive_o;
  int n_fail = 0, checked = 0;
  always #20 clk_i = ~clk_i;
  ldc_ctrl #(.CAL_CYCLES(CAL)) u_dut (.*);
  ldc_host_model u_host (.clk_i(clk_i), .go_i(go), .pwm_i(pwm), .kick_i(kick),
    .pulse_o(dimming_pulse_input_i), .en_o(calibration_enable_i), .start_o(calibration_start_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_dim(input logic lh, input logic [7:0] sp, ad);
    return lh ? sp : ad;
  endfunction
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 chk(dim_level_o, DIM_RST);
    chk(calibration_value_o, CAL_RST);
    @(posedge clk_i) resetn_i <= 1;
    void'($urandom(85097));
    repeat (400) begin
      @(posedge clk_i);
      {pwm, enable_undervoltage_input_i, idle_i, limp_home_input_i, pwm_hs_req_i, kick,
        regulation_mode_i} <= 8'($urandom);
      {analog_dim_value_i, setpoint_level_i, calibration_value_wr_i} <= 24'($urandom);
      @(posedge clk_i);
      #1 chk(dim_level_o, exp_dim(limp_home_input_i, setpoint_level_i, analog_dim_value_i));
      chk(8'(limp_home_o), 8'(limp_home_input_i));
      chk(8'(drivers_enabled_o), 8'(pwm & enable_undervoltage_input_i & !idle_i));
      if (pwm && regulation_mode_i != MODE_NONE) em = regulation_mode_i;
      chk(8'(regulation_mode_feedback_o), 8'(em));
      chk(calibration_value_o, calibration_value_wr_i);
    end
    @(posedge clk_i);
    {pwm, enable_undervoltage_input_i, idle_i, pwm_hs_req_i, kick} <= 5'b11000;
    limp_home_input_i <= 1'b0;
    analog_dim_value_i <= DIM_TEN_PCT;
    @(posedge clk_i);
    #1 chk(dim_level_o, DIM_TEN_PCT);
    repeat (4) @(posedge clk_i);
    #1 chk(8'({high_side_gate_drive_o, low_side_gate_drive_o}), 8'h1);
    @(posedge clk_i) pwm_hs_req_i <= 1;
    repeat (3) @(posedge clk_i);
    #1 chk(8'({high_side_gate_drive_o, low_side_gate_drive_o}), 8'h2);
    @(posedge clk_i) pwm_hs_req_i <= 0;
    repeat (3) @(posedge clk_i);
    #1 chk(8'({high_side_gate_drive_o, low_side_gate_drive_o}), 8'h1);
    @(posedge clk_i);
    go <= 1;
    cal_measure_i <= 8'($urandom);
    for (int i = 0; i < CAL + 9 && calibration_done_o !== 1'b1; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    #1 chk(8'(calibration_done_o), 8'h1);
    chk(calibration_value_o, cal_measure_i);
    chk(cal_trim_o, cal_measure_i);
    @(posedge clk_i) go <= 0;
    repeat (2) @(posedge clk_i);
    go <= 1;
    repeat (6) @(posedge clk_i);
    #1 chk(8'(calibration_done_o), 8'h0);
    @(posedge clk_i) go <= 0;
    repeat (CAL + 5) @(posedge clk_i);
    #1 chk(8'({cal_busy_o, calibration_done_o}), 8'h0);
    give_verdict();
  end
endmodule
